// ### src/pst_pkg.sv
// package of constants, types and helpers for the protection stage timing block
package pst_pkg;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYCLE_US = 5000;
  localparam int CYCLE_CLKS = (CLK_HZ / 1_000_000) * CYCLE_US;
  localparam int DIV_W = 17;
  localparam int BLOCK_LEAD_US = 5000;
  // hysteresis in percent of setting
  localparam logic [7:0] RESET_PCT = 8'h61;
  localparam logic [7:0] FULL_PCT = 8'h64;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PICKUP = 12'h004;
  localparam logic [11:0] OFS_DELAY = 12'h008;
  localparam logic [11:0] OFS_TDIAL = 12'h00c;
  localparam logic [11:0] OFS_GAIN = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_EVT_TIME = 12'h018;
  localparam logic [11:0] OFS_EVT_MAG = 12'h01c;
  // control field positions
  localparam int CTRL_TYPE_BIT = 0;
  localparam int CTRL_SERIES_BIT = 1;
  localparam int CTRL_DIR_BIT = 2;
  localparam int CTRL_CURVE_LSB = 3;
  // reset values
  localparam logic [15:0] PICKUP_RST = 16'h0064;
  localparam logic [18:0] DELAY_RST = 19'h00008;
  localparam logic [15:0] TDIAL_RST = 16'h0005;
  localparam logic [7:0] GAIN_RST = 8'h10;
  // curve codes
  localparam logic [2:0] IEC_PARAM = 3'h4;
  localparam logic [2:0] IEEE_PARAM = 3'h7;

  typedef enum logic {definite_delay_mode, inverse_delay_mode} pst_dly_t;
  typedef enum logic {SERIES_IEC, SERIES_IEEE} pst_series_t;

  typedef struct packed {
    pst_dly_t dly_type;
    pst_series_t series;
    logic under;
    logic [2:0] curve;
    logic [15:0] pickup_setting;
    logic [18:0] delay;
    logic [15:0] tdial;
    logic [7:0] gain;
  } pst_cfg_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] mag;
    logic under;
  } pst_evt_t;

  function automatic logic [23:0] pct(input logic [15:0] x, input logic [7:0] p);
    pct = 24'(x) * 24'(p);
  endfunction

  // true when the magnitude has crossed the setting in the guarded direction
  function automatic logic crossed(input logic [15:0] m, input logic [15:0] s,
                                   input logic under);
    crossed = under ? (m <= s) : (m >= s);
  endfunction

  // true when the magnitude is back past the reset level: 97 % of the setting over-limit, 100/97 of it under-limit
  function automatic logic released(input logic [15:0] m, input logic [15:0] s,
                                    input logic under);
    released = under ? (pct(m, RESET_PCT) > pct(s, FULL_PCT))
                     : (pct(m, FULL_PCT) < pct(s, RESET_PCT));
  endfunction

  // weighting of the excess per program cycle for each curve
  function automatic logic [7:0] curve_gain(input pst_series_t ser, input logic [2:0] c,
                                            input logic [7:0] user);
    logic [3:0] k;
    k = {ser == SERIES_IEEE, c};
    unique case (k)
      4'h0: curve_gain = 8'h08;
      4'h1: curve_gain = 8'h40;
      4'h2: curve_gain = 8'h20;
      4'h3: curve_gain = 8'h02;
      4'h8: curve_gain = 8'h08;
      4'h9: curve_gain = 8'h20;
      4'ha: curve_gain = 8'h40;
      4'hb: curve_gain = 8'h02;
      4'hc: curve_gain = 8'h04;
      4'hd: curve_gain = 8'h18;
      4'he: curve_gain = 8'h30;
      default: curve_gain = user;
    endcase
  endfunction
endpackage

// ### src/pst_pickup.sv
// pick-up element with fixed reset hysteresis
`timescale 1ns/1ps
module pst_pickup import pst_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // program cycle enable
  input wire logic tick,
  // magnitude and setting
  input wire logic [15:0] measured_magnitude,
  input wire logic [15:0] pickup_setting,
  input wire logic under,
  // element state
  output logic active
);
  typedef struct packed {
    logic active;
  } pst_pu_st_t;

  pst_pu_st_t st_r;
  pst_pu_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      if (!st_r.active) begin
        st_nxt.active = crossed(measured_magnitude, pickup_setting, under);
      end else if (released(measured_magnitude, pickup_setting, under)) begin
        st_nxt.active = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.active;
endmodule

// ### src/pst_invtime.sv
// inverse-time integrator: weighted excess accumulated each program cycle
`timescale 1ns/1ps
module pst_invtime import pst_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic step,
  input wire logic clear,
  // operands
  input wire logic [15:0] excess,
  input wire logic [7:0] gain,
  input wire logic [15:0] tdial,
  // result
  output logic done
);
  typedef struct packed {
    logic [31:0] acc;
    logic done;
  } pst_inv_st_t;

  pst_inv_st_t st_r;
  pst_inv_st_t st_nxt;

  always_comb begin
    logic [32:0] sum;
    sum = 33'(st_r.acc) + 33'(24'(excess) * 24'(gain));
    st_nxt = st_r;
    if (clear) begin
      st_nxt = '0;
    end else if (step) begin
      // saturate so a long fault never wraps back below the target
      st_nxt.acc = sum[32] ? 32'hffffffff : sum[31:0];
      st_nxt.done = (st_nxt.acc >= {tdial, 16'h0000});
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule

// ### src/pst_stage.sv
// protection stage: APB settings, blocking, start, trip timing and blocking events
`timescale 1ns/1ps
module pst_stage import pst_pkg::*; #(
  parameter int CYCLE_LEN = CYCLE_CLKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement and blocking matrix
  input wire logic [15:0] measured_magnitude,
  input wire logic block_in,
  // stage outputs
  output logic start,
  output logic stage_inhibited,
  output logic trip,
  // blocking event
  output logic evt_valid,
  output pst_evt_t evt
);
  typedef enum logic [1:0] {S_IDLE, S_TIMING, S_TRIPPED, S_INHIBIT} pst_fsm_t;

  typedef struct packed {
    pst_cfg_t cfg;
    logic [DIV_W-1:0] div;
    logic tick;
    logic proc;
    logic blk;
    pst_fsm_t fsm;
    logic [18:0] tmr;
    logic [31:0] stamp;
    logic start;
    logic inhib;
    logic trip;
    logic evt_valid;
    pst_evt_t evt;
    logic [31:0] prdata;
  } pst_st_t;

  pst_st_t st_r;
  pst_st_t st_nxt;
  logic pu;
  logic inv_done;
  logic [15:0] excess;
  logic instant;
  logic wr_en;
  logic rd_setup;
  logic mapped;

  // settings reset values: definite mode, IEC series, over-limit
  function automatic pst_cfg_t cfg_reset();
    pst_cfg_t c;
    c = '0;
    c.dly_type = definite_delay_mode;
    c.series = SERIES_IEC;
    c.pickup_setting = PICKUP_RST;
    c.delay = DELAY_RST;
    c.tdial = TDIAL_RST;
    c.gain = GAIN_RST;
    return c;
  endfunction

  // reset image of the settings, fixed at elaboration so the reset branch stays constant
  localparam pst_cfg_t CFG_RST = cfg_reset();

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == OFS_CTRL) || (a == OFS_PICKUP) || (a == OFS_DELAY) ||
           (a == OFS_TDIAL) || (a == OFS_GAIN) || (a == OFS_STATUS) ||
           (a == OFS_EVT_TIME) || (a == OFS_EVT_MAG);
  endfunction

  pst_pickup u_pickup (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(st_r.tick),
    .measured_magnitude(measured_magnitude),
    .pickup_setting(st_r.cfg.pickup_setting),
    .under(st_r.cfg.under),
    .active(pu)
  );

  // excess over the setting in the guarded direction drives the curve
  always_comb begin
    if (st_r.cfg.under) begin
      excess = (st_r.cfg.pickup_setting > measured_magnitude) ?
               16'(st_r.cfg.pickup_setting - measured_magnitude) : 16'h0000;
    end else begin
      excess = (measured_magnitude > st_r.cfg.pickup_setting) ?
               16'(measured_magnitude - st_r.cfg.pickup_setting) : 16'h0000;
    end
  end

  pst_invtime u_invtime (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .step(st_r.proc && st_r.fsm == S_TIMING && pu && !st_r.blk),
    .clear(st_r.fsm != S_TIMING),
    .excess(excess),
    .gain(curve_gain(st_r.cfg.series, st_r.cfg.curve, st_r.cfg.gain)),
    .tdial(st_r.cfg.tdial),
    .done(inv_done)
  );

  assign instant = (st_r.cfg.dly_type == definite_delay_mode) &&
                   (st_r.cfg.delay == 19'h00000);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = is_mapped(paddr);

  always_comb begin
    logic [18:0] tmr_inc;
    logic dt_due;
    logic min_due;
    tmr_inc = st_r.tmr + 19'h00001;
    dt_due = tmr_inc >= st_r.cfg.delay;
    min_due = dt_due || (st_r.cfg.delay == 19'h00000);
    st_nxt = st_r;
    st_nxt.evt_valid = 1'b0;
    // program cycle divider
    st_nxt.tick = 1'b0;
    if (st_r.div == DIV_W'(CYCLE_LEN - 1)) begin
      st_nxt.div = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.div = st_r.div + 1'b1;
    end
    st_nxt.proc = st_r.tick;
    if (st_r.tick) begin
      st_nxt.blk = block_in;
      st_nxt.stamp = st_r.stamp + 32'h00000001;
    end
    // stage evaluation one clock after the sample
    if (st_r.proc) begin
      unique case (st_r.fsm)
        S_IDLE: begin
          if (pu && st_r.blk) begin
            st_nxt.inhib = 1'b1;
            st_nxt.fsm = S_INHIBIT;
            st_nxt.evt_valid = 1'b1;
            st_nxt.evt = '{stamp: st_r.stamp, mag: measured_magnitude,
                           under: st_r.cfg.under};
          end else if (pu) begin
            st_nxt.start = 1'b1;
            st_nxt.tmr = '0;
            if (instant) begin
              st_nxt.trip = 1'b1;
              st_nxt.fsm = S_TRIPPED;
            end else begin
              st_nxt.fsm = S_TIMING;
            end
          end
        end
        S_TIMING: begin
          if (st_r.blk) begin
            // release handling as on a pick-up reset
            st_nxt.start = 1'b0;
            st_nxt.tmr = '0;
            st_nxt.inhib = 1'b1;
            st_nxt.fsm = S_INHIBIT;
            st_nxt.evt_valid = 1'b1;
            st_nxt.evt = '{stamp: st_r.stamp, mag: measured_magnitude,
                           under: st_r.cfg.under};
          end else if (!pu) begin
            st_nxt.start = 1'b0;
            st_nxt.tmr = '0;
            st_nxt.fsm = S_IDLE;
          end else begin
            st_nxt.tmr = tmr_inc;
            if (st_r.cfg.dly_type == definite_delay_mode) begin
              if (dt_due) begin
                st_nxt.trip = 1'b1;
                st_nxt.fsm = S_TRIPPED;
              end
            end else if (inv_done && min_due) begin
              st_nxt.trip = 1'b1;
              st_nxt.fsm = S_TRIPPED;
            end
          end
        end
        S_TRIPPED: begin
          if (st_r.blk) begin
            st_nxt.start = 1'b0;
            st_nxt.trip = 1'b0;
            st_nxt.tmr = '0;
            st_nxt.inhib = 1'b1;
            st_nxt.fsm = S_INHIBIT;
            st_nxt.evt_valid = 1'b1;
            st_nxt.evt = '{stamp: st_r.stamp, mag: measured_magnitude,
                           under: st_r.cfg.under};
          end else if (!pu) begin
            st_nxt.start = 1'b0;
            st_nxt.trip = 1'b0;
            st_nxt.tmr = '0;
            st_nxt.fsm = S_IDLE;
          end
        end
        S_INHIBIT: begin
          // no further processing until the element resets
          if (!pu) begin
            st_nxt.inhib = 1'b0;
            st_nxt.fsm = S_IDLE;
          end
        end
      endcase
    end
    // register writes
    if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: begin
          st_nxt.cfg.dly_type = pst_dly_t'(pwdata[CTRL_TYPE_BIT]);
          st_nxt.cfg.series = pst_series_t'(pwdata[CTRL_SERIES_BIT]);
          st_nxt.cfg.under = pwdata[CTRL_DIR_BIT];
          st_nxt.cfg.curve = pwdata[CTRL_CURVE_LSB +: 3];
        end
        OFS_PICKUP: st_nxt.cfg.pickup_setting = pwdata[15:0];
        OFS_DELAY: st_nxt.cfg.delay = pwdata[18:0];
        OFS_TDIAL: st_nxt.cfg.tdial = pwdata[15:0];
        OFS_GAIN: st_nxt.cfg.gain = pwdata[7:0];
        default: ;
      endcase
    end
    // read data captured in the setup cycle
    if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL: st_nxt.prdata = 32'({st_r.cfg.curve, st_r.cfg.under, st_r.cfg.series,
                                      st_r.cfg.dly_type});
        OFS_PICKUP: st_nxt.prdata = 32'(st_r.cfg.pickup_setting);
        OFS_DELAY: st_nxt.prdata = 32'(st_r.cfg.delay);
        OFS_TDIAL: st_nxt.prdata = 32'(st_r.cfg.tdial);
        OFS_GAIN: st_nxt.prdata = 32'(st_r.cfg.gain);
        OFS_STATUS: st_nxt.prdata = 32'({st_r.fsm, st_r.blk, pu, st_r.trip, st_r.inhib,
                                        st_r.start});
        OFS_EVT_TIME: st_nxt.prdata = st_r.evt.stamp;
        OFS_EVT_MAG: st_nxt.prdata = 32'({st_r.evt.under, st_r.evt.mag});
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{cfg: CFG_RST, fsm: S_IDLE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_r.prdata;
  assign start = st_r.start;
  assign stage_inhibited = st_r.inhib;
  assign trip = st_r.trip;
  assign evt_valid = st_r.evt_valid;
  assign evt = st_r.evt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_block_sample: assert property (st_r.tick |=> st_r.blk == $past(block_in))
    else $error("blocking input not sampled at program cycle start");

  a_pickup_hold: assert property (st_r.tick && pu &&
      !released(measured_magnitude, st_r.cfg.pickup_setting, st_r.cfg.under)
      |=> pu)
    else $error("pick-up released above reset level");

  a_pickup_set: assert property (st_r.tick && !pu &&
      crossed(measured_magnitude, st_r.cfg.pickup_setting, st_r.cfg.under)
      |=> pu)
    else $error("pick-up not set after crossing");

  a_instant_trip: assert property (st_r.proc && st_r.fsm == S_IDLE && pu && !st_r.blk &&
      instant |=> start && trip)
    else $error("instant trip not with start");

  a_stage_inhibited_pickup: assert property (st_r.proc && st_r.fsm == S_IDLE && pu && st_r.blk
      |=> stage_inhibited && evt_valid && !start && !trip)
    else $error("stage_inhibited pick-up not inhibited");

  a_block_clears_start: assert property (st_r.proc && st_r.fsm == S_TIMING && st_r.blk
      |=> !start && stage_inhibited && evt_valid ##1 !evt_valid)
    else $error("blocking did not clear start");

  a_event_stamp: assert property ($rose(stage_inhibited) |-> evt_valid &&
      evt.stamp == $past(st_r.stamp))
    else $error("blocking event missing or badly stamped");

  a_dt_on_time: assert property (st_r.proc && st_r.fsm == S_TIMING && pu && !st_r.blk &&
      st_r.cfg.dly_type == definite_delay_mode && st_r.tmr + 19'h00001 >= st_r.cfg.delay
      |=> trip)
    else $error("definite trip late");

  a_no_early_trip: assert property ($rose(trip) && st_r.cfg.delay != 19'h00000
      |-> st_r.tmr >= st_r.cfg.delay)
    else $error("trip before minimum time");

  a_release_clears: assert property (st_r.proc && st_r.fsm != S_INHIBIT && !pu
      |=> !start && !trip && st_r.tmr == 19'h00000)
    else $error("release did not clear start and timer");

  a_trip_with_start: assert property (trip |-> start && !stage_inhibited)
    else $error("trip without start");

  // start only rises from a live pick-up, with the timer counting from zero
  a_start_rise: assert property ($rose(start) |-> pu && !stage_inhibited &&
      st_r.tmr == 19'h00000)
    else $error("start raised without a clean pick-up");

  a_inhib_quiet: assert property (stage_inhibited |-> !start && !trip)
    else $error("start or trip while inhibited");

  // inhibit is left only by an evaluation that sees the element released
  a_inhib_holds: assert property (stage_inhibited && !(st_r.proc && !pu)
      |=> stage_inhibited)
    else $error("inhibit dropped while element still active");

  a_event_pulse: assert property (evt_valid |=> !evt_valid)
    else $error("blocking event longer than one clock");

  a_eval_after_sample: assert property (st_r.tick |=> st_r.proc)
    else $error("evaluation does not follow the blocking sample");

  a_idle_quiet: assert property (st_r.fsm == S_IDLE |-> !start && !trip &&
      !stage_inhibited)
    else $error("outputs active in idle");

  // an inverse trip needs the integrator target reached, whatever the floor
  a_inv_target: assert property ($rose(trip) &&
      st_r.cfg.dly_type == inverse_delay_mode |-> inv_done)
    else $error("inverse trip before curve time");

  c_instant: cover property (instant && $rose(trip) && $rose(start));
  c_dt_trip: cover property ($rose(trip) && st_r.cfg.dly_type == definite_delay_mode &&
      !instant);
  c_inverse_delay_mode_trip: cover property ($rose(trip) && st_r.cfg.dly_type == inverse_delay_mode);
  c_block_start: cover property ($fell(start) && stage_inhibited);
endmodule

// ### verification/pst_front_end_model.sv
// model of the blocking matrix and the measured-value front end
`timescale 1ns/1ps
module pst_front_end_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // values requested by the bench
  input wire logic [15:0] mag_req,
  input wire logic blk_req,
  // values seen by the stage
  output logic [15:0] measured_magnitude,
  output logic block_in
);
  // a request reaches the stage one clock later, as a sampled front end would
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      measured_magnitude <= 16'h0000;
      block_in <= 1'b0;
    end else begin
      measured_magnitude <= mag_req;
      block_in <= blk_req;
    end
  end
endmodule

// ### verification/tb_top.sv
// self-checking bench for the protection stage
`timescale 1ns/1ps
module tb_top import pst_pkg::*;;
  localparam int CL = 10;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] mag_req = 16'h0000;
  logic blk_req = 1'b0;
  logic [15:0] measured_magnitude;
  logic block_in;
  logic start;
  logic stage_inhibited;
  logic trip;
  logic evt_valid;
  pst_evt_t evt;
  int errors = 0;
  int cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  pst_front_end_model FE (.clk_sys(clk_sys), .sys_rst(sys_rst), .mag_req(mag_req),
    .blk_req(blk_req), .measured_magnitude(measured_magnitude), .block_in(block_in));

  pst_stage #(.CYCLE_LEN(CL)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measured_magnitude(measured_magnitude),
    .block_in(block_in), .start(start), .stage_inhibited(stage_inhibited), .trip(trip),
    .evt_valid(evt_valid), .evt(evt));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // wait states end only on pready; the watchdog bounds a hang
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(a, 1'b1, d, rd, er);
  endtask

  task automatic drive(input logic [15:0] m, input logic b);
    @(posedge clk_sys);
    mag_req <= m;
    blk_req <= b;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // sel 0 waits for start, 1 for trip, 2 for inhibited; n counts edges
  task automatic wait_out(input int sel, output int n);
    logic hit;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      hit = (sel == 0) ? start : (sel == 1) ? trip : stage_inhibited;
    end while (hit !== 1'b1 && n < 400 * CL);
    check(hit, 1'b1);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic e;
    apb(OFS_CTRL, 1'b0, 32'h0, d, e);
    check(d, 32'h00000000);
    apb(OFS_DELAY, 1'b0, 32'h0, d, e);
    check(d, 32'h00000008);
    apb(12'h020, 1'b1, 32'hffffffff, d, e);
    check(e, 1'b1);
    apb(12'h020, 1'b0, 32'h0, d, e);
    check({e, d}, {1'b1, 32'h00000000});
    $display("test regs done");
  endtask

  task automatic t_def();
    int n;
    drive(16'h00c8, 1'b0);
    wait_out(0, n);
    check({start, trip}, 2'b10);
    wait_out(1, n);
    check(n, 8 * CL);
    drive(16'h0062, 1'b0);
    idle(3 * CL);
    check({start, trip}, 2'b11);
    drive(16'h0060, 1'b0);
    idle(3 * CL);
    check({start, trip}, 2'b00);
    drive(16'h00c8, 1'b0);
    wait_out(0, n);
    idle(4 * CL);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    check({start, trip}, 2'b00);
    drive(16'h00c8, 1'b0);
    wait_out(0, n);
    wait_out(1, n);
    check(n, 8 * CL);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    $display("test definite done");
  endtask

  task automatic t_inst();
    int n;
    wr(OFS_DELAY, 32'h0);
    drive(16'h00c8, 1'b0);
    wait_out(0, n);
    check(trip, 1'b1);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    wr(OFS_DELAY, 32'h8);
    $display("test instant done");
  endtask

  task automatic t_block();
    int n;
    logic [31:0] d;
    logic e;
    logic [31:0] s0;
    drive(16'h00c8, 1'b1);
    wait_out(2, n);
    check({start, trip, evt_valid}, 3'b001);
    check({evt.mag, evt.under}, {16'h00c8, 1'b0});
    s0 = evt.stamp;
    apb(OFS_EVT_MAG, 1'b0, 32'h0, d, e);
    check(d, 32'h000000c8);
    drive(16'h00c8, 1'b0);
    idle(12 * CL);
    check({stage_inhibited, start, trip}, 3'b100);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    drive(16'h00c8, 1'b0);
    wait_out(0, n);
    idle(2 * CL);
    drive(16'h00c8, 1'b1);
    wait_out(2, n);
    check({start, evt_valid}, 2'b01);
    check(evt.stamp > s0, 1'b1);
    idle(10 * CL);
    check(trip, 1'b0);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    $display("test blocking done");
  endtask

  task automatic t_under();
    int n;
    wr(OFS_CTRL, 32'h4);
    drive(16'h0032, 1'b0);
    wait_out(0, n);
    check(start, 1'b1);
    drive(16'h0066, 1'b0);
    idle(3 * CL);
    check(start, 1'b1);
    drive(16'h0068, 1'b0);
    idle(3 * CL);
    check(start, 1'b0);
    wr(OFS_CTRL, 32'h0);
    drive(16'h0000, 1'b0);
    idle(3 * CL);
    $display("test under-limit done");
  endtask

  task automatic t_inv();
    int n;
    logic [31:0] modes [3] = '{32'h1, 32'h3, 32'h21};
    wr(OFS_DELAY, 32'h4);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        wr(OFS_DELAY, 32'h0);
      end
      wr(OFS_CTRL, modes[i % 3]);
      drive(16'hffff, 1'b0);
      wait_out(0, n);
      wait_out(1, n);
      check(trip, 1'b1);
      check((i == 3) ? (n < 4 * CL) : (n >= 4 * CL), 1'b1);
      drive(16'h0000, 1'b0);
      idle(3 * CL);
    end
    wr(OFS_CTRL, 32'h0);
    $display("test inverse done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_def();
    t_inst();
    t_block();
    t_under();
    t_inv();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
endmodule
